// file: design/spf_defines.svh
// Purpose: constants of the serial packet framer
// Assumes: 40 MHz system clock, 9600 baud 8N1 line
// Notes:   the framing byte values, fifo depth and bit timing count live here
// Contract
// - full duplex 9600 baud, eight data bits, no parity, one stop bit.
// - packet is lead, id, size, payload, checksum, lead, terminator.
// - every packet opens with the escape byte 0x10.
// - second byte is the packet identifier that names the payload kind.
// - third byte counts payload bytes, zero to 255.
// - checksum is two's complement of id, size and payload sum.
// - packet closes with escape byte then end-of-text 0x03.
// - escape in size, payload or checksum is doubled; duplicate not counted.
// - data packets are answered by ack 6 or nak 21 carrying their id.
// - sender holds further packets until answered, resends on nak.
// - escape and end-of-text never serve as packet identifiers; the receiver drops such packets, but i_tx_id is sent unchecked.
`ifndef SPF_DEFINES_SVH
`define SPF_DEFINES_SVH

`define SPF_CLK_HZ     40000000
`define SPF_BAUD       9600
// nearest whole cycle; the bit period is a nominal rate, not a bound
`define SPF_BIT_CYCLES ((`SPF_CLK_HZ + (`SPF_BAUD / 2)) / `SPF_BAUD)
`define SPF_DATA_BITS  8
`define SPF_ESC        8'h10
`define SPF_ETX        8'h03
`define SPF_ACK        8'h06
`define SPF_NAK        8'h15
`define SPF_FIFO_DEPTH 8

`endif

// file: design/spf_pkg.sv
// Purpose: types of the serial packet framer
// Assumes: constants come from spf_defines.svh
// Notes:   state encodings only
package spf_pkg;
	typedef enum logic [2:0] {
		PK_IDLE = 3'b000,
		PK_LEAD = 3'b001,
		PK_ID   = 3'b010,
		PK_SIZE = 3'b011,
		PK_DATA = 3'b100,
		PK_SUM  = 3'b101,
		PK_TAIL = 3'b110,
		PK_END  = 3'b111
	} pk_state_t;
endpackage : spf_pkg

// file: design/serial_packet_framer.sv
// Purpose: packet framer and deframer over one 8N1 serial line pair
// Assumes: synchronous active-high reset, inputs synchronous to i_clk_sys
// Notes:   received payload is streamed before its checksum is known;
//          o_rx_good (not raised for ack or nak) or o_rx_bad at the end says whether to keep it
`include "spf_defines.svh"
`timescale 1ns/100ps
`default_nettype none

// small valid/ready fifo in front of the transmit payload
module spf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `SPF_FIFO_DEPTH
) (
	input  wire logic             i_clk_sys,
	input  wire logic             i_rst,
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	output logic                  o_out_valid,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	wire              push = i_in_valid && o_in_ready;
	wire              pop  = o_out_valid && i_out_ready;

	assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_q != '0);
	assign o_out_data  = mem_q[rd_q];

	// pointers wrap on depth, which need not be a power of two
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (push) mem_q[wr_q] <= i_in_data;
	end
endmodule : spf_fifo

module serial_packet_framer
	import spf_pkg::*;
#(
	parameter int P_BIT_CYCLES = `SPF_BIT_CYCLES
) (
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst,
	input  wire logic       i_rxd,
	output logic            o_txd,
	input  wire logic       i_tx_start,
	input  wire logic [7:0] i_tx_id,
	input  wire logic [7:0] i_tx_size,
	output logic            o_tx_ready,
	input  wire logic       i_pl_valid,
	input  wire logic [7:0] i_pl_data,
	output logic            o_pl_ready,
	output logic            o_tx_acked,
	output logic            o_tx_nacked,
	output logic            o_rx_valid,
	output logic [7:0]      o_rx_data,
	output logic [7:0]      o_rx_id,
	output logic            o_rx_good,
	output logic            o_rx_bad
);
	localparam int CW = $clog2(P_BIT_CYCLES + 1);
	localparam logic [CW-1:0] BIT_LAST  = CW'(P_BIT_CYCLES - 1);
	localparam logic [CW-1:0] HALF_LAST = CW'(P_BIT_CYCLES / 2 - 1);

	// ---- serial transmitter: start, 8 data lsb first, stop ----
	logic [CW-1:0] tb_cnt_q;
	logic [3:0]    tb_bit_q;
	logic [9:0]    tb_sh_q;
	logic          tb_busy_q;
	logic          ub_go;
	logic [7:0]    ub_byte;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			tb_busy_q <= 1'b0;
			tb_sh_q   <= 10'h3FF;
			tb_cnt_q  <= '0;
			tb_bit_q  <= 4'h0;
		end else if (!tb_busy_q) begin
			if (ub_go) begin
				tb_busy_q <= 1'b1;
				tb_sh_q   <= {1'b1, ub_byte, 1'b0};
				tb_cnt_q  <= '0;
				tb_bit_q  <= 4'h0;
			end
		end else if (tb_cnt_q == BIT_LAST) begin
			tb_cnt_q <= '0;
			tb_sh_q  <= {1'b1, tb_sh_q[9:1]};
			tb_bit_q <= tb_bit_q + 4'h1;
			if (tb_bit_q == 4'h9) tb_busy_q <= 1'b0;
		end else begin
			tb_cnt_q <= tb_cnt_q + 1'b1;
		end
	end
	assign o_txd = tb_sh_q[0];

	// ---- serial receiver: mid-bit sampling, stop bit must be high ----
	logic [CW-1:0] rb_cnt_q;
	logic [3:0]    rb_bit_q;
	logic [7:0]    rb_sh_q;
	logic          rb_busy_q;
	logic          rb_valid_q;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			rb_busy_q  <= 1'b0;
			rb_cnt_q   <= '0;
			rb_bit_q   <= 4'h0;
			rb_sh_q    <= 8'h00;
			rb_valid_q <= 1'b0;
		end else begin
			rb_valid_q <= 1'b0;
			if (!rb_busy_q) begin
				rb_busy_q <= !i_rxd;
				rb_cnt_q  <= '0;
				rb_bit_q  <= 4'h0;
			end else if ((rb_bit_q == 4'h0) ? (rb_cnt_q == HALF_LAST)
			                                : (rb_cnt_q == BIT_LAST)) begin
				rb_cnt_q <= '0;
				rb_bit_q <= rb_bit_q + 4'h1;
				if (rb_bit_q == 4'h0 && i_rxd) rb_busy_q <= 1'b0; // glitch, not a start
				if (rb_bit_q >= 4'h1 && rb_bit_q <= 4'h8) rb_sh_q <= {i_rxd, rb_sh_q[7:1]};
				if (rb_bit_q == 4'h9) begin
					rb_busy_q  <= 1'b0;
					rb_valid_q <= i_rxd;
				end
			end else begin
				rb_cnt_q <= rb_cnt_q + 1'b1;
			end
		end
	end

	// ---- packet receiver ----
	pk_state_t rx_st_q;
	logic [7:0] rlen_q, ridx_q, rsum_q, rfirst_q;
	logic       dup_q;
	logic       ans_set, ack_ev, nak_ev;
	wire  [7:0] rb       = rb_sh_q;
	wire  [7:0] rsum_nx  = rsum_q + rb;
	wire        rb_esc   = (rb == `SPF_ESC);
	wire        r_answer = (o_rx_id == `SPF_ACK) || (o_rx_id == `SPF_NAK);
	wire        dup_bad  = dup_q && !rb_esc;
	wire        tail_bad = (rx_st_q == PK_TAIL && !rb_esc)
	                    || (rx_st_q == PK_END && (rb != `SPF_ETX || rsum_q != 8'h00));
	wire        r_bad    = rb_valid_q && (dup_bad || (!dup_q && tail_bad));
	wire        r_good   = rb_valid_q && !dup_q && rx_st_q == PK_END && !tail_bad;
	logic [7:0] data_pid_q;

	assign ans_set = (r_bad && !r_answer) || (r_good && !r_answer);
	assign ack_ev  = r_good && o_rx_id == `SPF_ACK && rfirst_q == data_pid_q;
	assign nak_ev  = r_good && o_rx_id == `SPF_NAK && rfirst_q == data_pid_q;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			rx_st_q    <= PK_IDLE;
			o_rx_id    <= 8'h00;
			rlen_q     <= 8'h00;
			ridx_q     <= 8'h00;
			rsum_q     <= 8'h00;
			rfirst_q   <= 8'h00;
			dup_q      <= 1'b0;
			o_rx_valid <= 1'b0;
			o_rx_data  <= 8'h00;
			o_rx_good  <= 1'b0;
			o_rx_bad   <= 1'b0;
		end else begin
			o_rx_valid <= 1'b0;
			o_rx_good  <= r_good && !r_answer;
			o_rx_bad   <= r_bad;
			if (rb_valid_q) begin
				if (dup_q) begin
					dup_q <= 1'b0;
					if (!rb_esc) rx_st_q <= PK_IDLE;
				end else begin
					case (rx_st_q)
						PK_IDLE: if (rb_esc) rx_st_q <= PK_ID;
						PK_ID: begin
							o_rx_id <= rb;
							rsum_q  <= rb;
							rx_st_q <= (rb_esc || rb == `SPF_ETX) ? PK_IDLE : PK_SIZE;
						end
						PK_SIZE: begin
							rlen_q  <= rb;
							rsum_q  <= rsum_nx;
							ridx_q  <= 8'h00;
							dup_q   <= rb_esc;
							rx_st_q <= (rb == 8'h00) ? PK_SUM : PK_DATA;
						end
						PK_DATA: begin
							rsum_q     <= rsum_nx;
							dup_q      <= rb_esc;
							o_rx_valid <= 1'b1;
							o_rx_data  <= rb;
							if (ridx_q == 8'h00) rfirst_q <= rb;
							ridx_q <= ridx_q + 8'h01;
							if (ridx_q == rlen_q - 8'h01) rx_st_q <= PK_SUM;
						end
						PK_SUM: begin
							rsum_q  <= rsum_nx;
							dup_q   <= rb_esc;
							rx_st_q <= PK_TAIL;
						end
						PK_TAIL: rx_st_q <= rb_esc ? PK_END : PK_IDLE;
						PK_END:  rx_st_q <= PK_IDLE;
						default: rx_st_q <= PK_IDLE;
					endcase
				end
			end
		end
	end

	// ---- packet transmitter ----
	pk_state_t tx_st_q;
	logic [7:0] buf_q [256];
	logic [7:0] data_len_q, idx_q, sum_q, ans_id_q;
	logic       ans_q, ans_pend_q, ans_nak_q, wait_q, resend_q, resend_pend_q, stuff_q;
	logic       f_valid;
	logic [7:0] f_data;
	logic [7:0] pid, len, pl_byte, cur_byte;

	assign pid     = ans_q ? (ans_nak_q ? `SPF_NAK : `SPF_ACK) : data_pid_q;
	assign len     = ans_q ? 8'h02 : data_len_q;
	assign pl_byte = ans_q ? ((idx_q == 8'h00) ? ans_id_q : 8'h00)
	                       : (resend_q ? buf_q[idx_q] : f_data);
	assign cur_byte = (tx_st_q == PK_ID)   ? pid :
	                  (tx_st_q == PK_SIZE) ? len :
	                  (tx_st_q == PK_DATA) ? pl_byte :
	                  (tx_st_q == PK_SUM)  ? (8'h00 - sum_q) :
	                  (tx_st_q == PK_END)  ? `SPF_ETX : `SPF_ESC;

	wire pl_avail   = ans_q || resend_q || f_valid;
	wire send_ok    = !tb_busy_q && tx_st_q != PK_IDLE
	               && (tx_st_q != PK_DATA || stuff_q || pl_avail);
	wire stuffable  = tx_st_q == PK_SIZE || tx_st_q == PK_DATA || tx_st_q == PK_SUM;
	wire need_stuff = stuffable && !stuff_q && cur_byte == `SPF_ESC;
	wire first      = send_ok && !stuff_q;
	wire advance    = send_ok && !need_stuff;
	wire fresh_pop  = first && tx_st_q == PK_DATA && !ans_q && !resend_q;

	assign ub_go      = send_ok;
	assign ub_byte    = stuff_q ? `SPF_ESC : cur_byte;
	assign o_pl_ready = 1'b0 || fresh_pop;
	// held low while the last char still shifts and while a resend is queued
	assign o_tx_ready = tx_st_q == PK_IDLE && !tb_busy_q && !ans_pend_q && !resend_pend_q
	                 && !wait_q && !ans_set;

	spf_fifo #(.WIDTH(8), .DEPTH(`SPF_FIFO_DEPTH)) u_pl_fifo (
		.i_clk_sys  (i_clk_sys),
		.i_rst      (i_rst),
		.i_in_valid (i_pl_valid),
		.i_in_data  (i_pl_data),
		.o_in_ready (),
		.o_out_valid(f_valid),
		.o_out_data (f_data),
		.i_out_ready(fresh_pop)
	);

	// fresh payload is kept so a nak can be answered without the source
	always_ff @(posedge i_clk_sys) begin
		if (fresh_pop) buf_q[idx_q] <= f_data;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			tx_st_q       <= PK_IDLE;
			data_pid_q    <= 8'h00;
			data_len_q    <= 8'h00;
			idx_q         <= 8'h00;
			sum_q         <= 8'h00;
			ans_id_q      <= 8'h00;
			{ans_q, ans_pend_q, ans_nak_q, wait_q} <= 4'h0;
			{resend_q, resend_pend_q, stuff_q}     <= 3'h0;
			o_tx_acked    <= 1'b0;
			o_tx_nacked   <= 1'b0;
		end else begin
			o_tx_acked  <= ack_ev && wait_q;
			o_tx_nacked <= nak_ev && wait_q;
			if (send_ok) stuff_q <= need_stuff;
			if (first && (tx_st_q == PK_ID || tx_st_q == PK_SIZE || tx_st_q == PK_DATA))
				sum_q <= (tx_st_q == PK_ID) ? cur_byte : sum_q + cur_byte;
			if (advance) begin
				case (tx_st_q)
					PK_LEAD: tx_st_q <= PK_ID;
					PK_ID:   tx_st_q <= PK_SIZE;
					PK_SIZE: tx_st_q <= (len == 8'h00) ? PK_SUM : PK_DATA;
					PK_DATA: begin
						idx_q <= idx_q + 8'h01;
						if (idx_q == len - 8'h01) tx_st_q <= PK_SUM;
					end
					PK_SUM:  tx_st_q <= PK_TAIL;
					PK_TAIL: tx_st_q <= PK_END;
					PK_END: begin
						tx_st_q <= PK_IDLE;
						if (!ans_q) wait_q <= 1'b1;
					end
					default: tx_st_q <= PK_IDLE;
				endcase
			end
			// answers go first, then a pending resend, then new data
			if (tx_st_q == PK_IDLE) begin
				idx_q <= 8'h00;
				if (ans_pend_q) begin
					{ans_q, ans_pend_q} <= 2'b10;
					tx_st_q <= PK_LEAD;
				end else if (resend_pend_q) begin
					{ans_q, resend_q, resend_pend_q} <= 3'b010;
					tx_st_q <= PK_LEAD;
				end else if (i_tx_start && o_tx_ready) begin
					{ans_q, resend_q} <= 2'b00;
					data_pid_q <= i_tx_id;
					data_len_q <= i_tx_size;
					tx_st_q    <= PK_LEAD;
				end
			end
			if (wait_q && ack_ev) wait_q <= 1'b0;
			if (wait_q && nak_ev) begin
				wait_q        <= 1'b0;
				resend_pend_q <= 1'b1;
			end
			// a new answer request wins over the clear at packet launch
			if (ans_set) begin
				ans_pend_q <= 1'b1;
				ans_nak_q  <= r_bad;
				ans_id_q   <= o_rx_id;
			end
		end
	end
endmodule : serial_packet_framer

`default_nettype wire

// file: verification/spf_assertions.sv
// Purpose: port-level properties of the serial packet framer
// Assumes: one clock, synchronous active-high reset
// Notes:   bit time handed on from the design parameter
`timescale 1ns/100ps
`default_nettype none
module spf_assertions #(
	parameter int P_BIT_CYCLES = 16
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic o_txd,
	input wire logic i_tx_start,
	input wire logic o_tx_ready,
	input wire logic o_pl_ready,
	input wire logic o_tx_acked,
	input wire logic o_tx_nacked,
	input wire logic o_rx_valid,
	input wire logic o_rx_good,
	input wire logic o_rx_bad
);
	// longest low run: start bit plus eight zero data bits
	localparam int LOW_MAX = 9 * P_BIT_CYCLES;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);
	sequence s_take;
		i_tx_start && o_tx_ready;
	endsequence
	sequence s_held;
		!o_tx_ready ##1 !o_tx_ready;
	endsequence
	property p_take;
		s_take |=> s_held;
	endproperty
	property p_reset;
		$fell(i_rst) |-> o_txd && o_tx_ready && !o_pl_ready;
	endproperty
	property p_idle;
		o_tx_ready |-> o_txd;
	endproperty
	property p_low;
		$fell(o_txd) |-> ##[1:LOW_MAX] o_txd;
	endproperty
	property p_ack;
		o_tx_acked |-> !$past(o_tx_ready) && !o_tx_nacked;
	endproperty
	property p_nak;
		o_tx_nacked |-> s_held;
	endproperty
	property p_rx;
		o_rx_good |-> !o_rx_bad && !o_rx_valid;
	endproperty
	property p_pl;
		o_pl_ready |-> !o_tx_ready;
	endproperty
	a_take: assert property (p_take) else $error("request not held off");
	a_reset: assert property (p_reset) else $error("bad state after reset");
	a_idle: assert property (p_idle) else $error("line low while idle");
	a_low: assert property (p_low) else $error("line low too long");
	a_ack: assert property (p_ack) else $error("ack while not waiting");
	a_nak: assert property (p_nak) else $error("nak did not hold sender");
	a_rx: assert property (p_rx) else $error("good clashes with bad");
	a_pl: assert property (p_pl) else $error("payload taken while idle");
endmodule : spf_assertions
`default_nettype wire

// file: verification/spf_host.sv
// Purpose: host side of the serial link, 8N1 characters
// Assumes: bit time given in system clock cycles
// Notes:   line idles high; received characters queue up in got_q
`timescale 1ns/100ps
`default_nettype none
module spf_host #(
	parameter int BIT = 16
) (
	input  wire logic i_clk_sys,
	input  wire logic i_line,
	output logic      o_line
);
	logic [7:0] got_q[$];
	initial o_line = 1'b1;
	// start low, lsb first, stop high
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			o_line = f[i];
			repeat (BIT) @(negedge i_clk_sys);
		end
	endtask : send_byte
	// sample mid-bit; a low stop bit loses the character
	always begin
		logic [7:0] b;
		@(negedge i_line);
		repeat (BIT / 2) @(posedge i_clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge i_clk_sys);
			b[i] = i_line;
		end
		repeat (BIT) @(posedge i_clk_sys);
		if (i_line === 1'b1) got_q.push_back(b);
	end
endmodule : spf_host
`default_nettype wire

// file: verification/serial_packet_framer_test.sv
// Purpose: self-checking bench of the serial packet framer
// Assumes: 16-cycle bit time keeps the run short
// Notes:   drivers queue expected bytes, monitors pop and compare
`timescale 1ns/100ps
`default_nettype none
module serial_packet_framer_test;
	localparam int BIT = 16;
	logic       i_clk_sys = 1'b0;
	logic       i_rst = 1'b1;
	logic       i_rxd, o_txd, i_tx_start, o_tx_ready, i_pl_valid, o_pl_ready;
	logic       o_tx_acked, o_tx_nacked, o_rx_valid, o_rx_good, o_rx_bad;
	logic [7:0] i_tx_id, i_tx_size, i_pl_data, o_rx_data, o_rx_id;
	logic [7:0] fq[$], tx_q[$], rx_q[$], last_q[$];
	logic [3:0] seen = 4'h0;
	int         n_errors = 0;
	int         num_checks = 0;
	int         n_pl = 0;
	int         n_pop = 0;

	always #12.5 i_clk_sys = ~i_clk_sys;

	serial_packet_framer #(.P_BIT_CYCLES(BIT)) u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.i_rxd(i_rxd), .o_txd(o_txd), .i_tx_start(i_tx_start), .i_tx_id(i_tx_id),
		.i_tx_size(i_tx_size), .o_tx_ready(o_tx_ready), .i_pl_valid(i_pl_valid),
		.i_pl_data(i_pl_data), .o_pl_ready(o_pl_ready), .o_tx_acked(o_tx_acked),
		.o_tx_nacked(o_tx_nacked), .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data),
		.o_rx_id(o_rx_id), .o_rx_good(o_rx_good), .o_rx_bad(o_rx_bad));
	spf_host #(.BIT(BIT)) u_host (.i_clk_sys(i_clk_sys), .i_line(o_txd), .o_line(i_rxd));

	task automatic chk(input logic [7:0] seen_v, input logic [7:0] exp);
		num_checks++;
		if (seen_v !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen %h want %h", $time, seen_v, exp);
		end
	endtask : chk

	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict

	// wire image of a packet, escapes doubled
	function automatic void mk(input logic [7:0] id, input logic [7:0] pl[$]);
		logic [7:0] s;
		logic [7:0] b[$];
		s = id + 8'(pl.size());
		foreach (pl[i]) s += pl[i];
		b = {8'(pl.size()), pl, 8'h00 - s};
		fq = {8'h10, id};
		foreach (b[i]) begin
			fq.push_back(b[i]);
			if (b[i] == 8'h10) fq.push_back(8'h10);
		end
		fq = {fq, 8'h10, 8'h03};
	endfunction : mk

	task automatic host_send;
		foreach (fq[i]) u_host.send_byte(fq[i]);
	endtask : host_send

	task automatic host_pkt(input logic [7:0] id, input logic [7:0] pl[$]);
		mk(id, pl);
		rx_q = {rx_q, pl};
		host_send();
	endtask : host_pkt

	// load fifo, then request; a byte of 0x10 forces doubling
	task automatic dev_send(input logic [7:0] id, input int n);
		logic [7:0] pl[$];
		for (int i = 0; i < n; i++) pl.push_back(i == 1 ? 8'h10 : 8'($urandom));
		foreach (pl[i]) begin
			i_pl_valid = 1'b1;
			i_pl_data = pl[i];
			@(negedge i_clk_sys);
		end
		i_pl_valid = 1'b0;
		n_pl += n;
		mk(id, pl);
		last_q = fq;
		tx_q = {tx_q, fq};
		chk({7'h00, o_tx_ready}, 8'h01);
		i_tx_start = 1'b1;
		i_tx_id = id;
		i_tx_size = 8'(n);
		@(negedge i_clk_sys);
		i_tx_start = 1'b0;
	endtask : dev_send

	task automatic drain;
		int k;
		k = 0;
		while (tx_q.size() != 0 && k < 20000) begin
			@(negedge i_clk_sys);
			k++;
		end
		chk(8'(tx_q.size()), 8'h00);
		chk(8'(n_pop), 8'(n_pl));
		repeat (2 * BIT) @(negedge i_clk_sys);
	endtask : drain

	// events are latched so a pulse during a send is not lost
	task automatic wait_ev(input int i);
		int k;
		k = 0;
		while (seen[i] !== 1'b1 && k < 20000) begin
			@(posedge i_clk_sys);
			k++;
		end
		chk({7'h00, seen[i]}, 8'h01);
		@(negedge i_clk_sys);
		seen[i] = 1'b0;
	endtask : wait_ev

	always @(posedge i_clk_sys) begin
		seen <= seen | {o_rx_bad, o_rx_good, o_tx_nacked, o_tx_acked};
		// each fresh payload byte leaves the fifo once; a resend replays a copy
		if (o_pl_ready === 1'b1) n_pop++;
		if (u_host.got_q.size() != 0)
			chk(u_host.got_q.pop_front(), tx_q.size() != 0 ? tx_q.pop_front() : 8'hXX);
		if (o_rx_valid === 1'b1)
			chk(o_rx_data, rx_q.size() != 0 ? rx_q.pop_front() : 8'hXX);
	end

	initial begin
		repeat (60000) @(posedge i_clk_sys);
		n_errors++;
		give_verdict();
	end

	initial begin
		i_tx_start = 1'b0;
		i_tx_id = 8'h00;
		i_tx_size = 8'h00;
		i_pl_valid = 1'b0;
		i_pl_data = 8'h00;
		void'($urandom(8432));
		repeat (5) @(negedge i_clk_sys);
		i_rst = 1'b0;
		chk({7'h00, o_txd}, 8'h01);
		// nak forces the same frame again; a second request is refused
		dev_send(8'h22, 3);
		@(negedge i_clk_sys);
		i_tx_start = 1'b1;
		@(negedge i_clk_sys);
		i_tx_start = 1'b0;
		drain();
		tx_q = last_q;
		host_pkt(8'h15, {8'h22, 8'h00});
		wait_ev(1);
		drain();
		host_pkt(8'h06, {8'h22, 8'h00});
		wait_ev(0);
		// empty and fifo-full payloads
		for (int n = 0; n <= 8; n += 8) begin
			dev_send(8'h40 + 8'(n), n);
			drain();
			host_pkt(8'h06, {8'h40 + 8'(n), 8'h00});
			wait_ev(0);
		end
		// noise before the lead, then a good packet answered by ack
		mk(8'h06, {8'h33, 8'h00});
		tx_q = fq;
		u_host.send_byte(8'h55);
		host_pkt(8'h33, {8'h10, 8'h5A});
		wait_ev(2);
		chk(o_rx_id, 8'h33);
		drain();
		// corrupted checksum: payload still streamed, flagged by o_rx_bad and answered by nak
		mk(8'h15, {8'h34, 8'h00});
		tx_q = fq;
		rx_q = {8'h01};
		mk(8'h34, {8'h01});
		fq[fq.size() - 3] ^= 8'h01;
		host_send();
		wait_ev(3);
		drain();
		give_verdict();
	end
endmodule : serial_packet_framer_test

bind serial_packet_framer spf_assertions #(.P_BIT_CYCLES(P_BIT_CYCLES)) u_chk (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .o_txd(o_txd), .i_tx_start(i_tx_start),
	.o_tx_ready(o_tx_ready), .o_pl_ready(o_pl_ready), .o_tx_acked(o_tx_acked),
	.o_tx_nacked(o_tx_nacked), .o_rx_valid(o_rx_valid), .o_rx_good(o_rx_good),
	.o_rx_bad(o_rx_bad));
`default_nettype wire
